// [dsrp_pkg.sv]
// Package: addresses, fields, reset values and counts of the serial register port
package dsrp_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [4:0] A_RES_LO = 5'h00;
    localparam logic [4:0] A_RES_HI = 5'h01;
    localparam logic [4:0] A_AMP = 5'h02;
    localparam logic [4:0] A_CONV_CTL = 5'h03;
    localparam logic [4:0] A_GAIN_CH = 5'h04;
    localparam logic [4:0] A_IO_LVL = 5'h05;
    localparam logic [4:0] A_IO_DIR = 5'h06;
    localparam logic [4:0] A_REF_OSC = 5'h07;
    localparam logic [4:0] A_SPC = 5'h18;
    localparam logic [4:0] A_ID = 5'h1f;
    // ----------------------------------------
    // Instruction and register fields
    // ----------------------------------------
    localparam int INS_DIRECT = 7;
    localparam int INS_READ = 6;
    localparam int INS_WIDE = 5;
    localparam int CNV_BIT = 7;
    localparam int SPC_LSB = 0;
    localparam int SPC_2W = 1;
    localparam int SPC_LEG = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ----------------------------------------
    // Counts
    // ----------------------------------------
    localparam logic [3:0] RESYNC_ZEROS = 4'h8;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam int unsigned START_FALLS = 2;
    localparam int unsigned CONV_FALLS_DEF = 16;
    typedef enum logic [1:0] {ST_INSTR, ST_WDATA, ST_RDATA} dsrp_state_t;
    typedef enum logic [1:0] {CV_IDLE, CV_WAIT, CV_RUN} dsrp_conv_t;
endpackage : dsrp_pkg

// [dsrp_edge.sv]
// Edge detector for a pin sampled on the system clock
module dsrp_edge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sig_i,
    output logic rise_o,
    output logic fall_o
);
    // ----------------------------------------
    // Previous level
    // ----------------------------------------
    logic prev_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sig_i;
        end
    end

    assign rise_o = sig_i & ~prev_reg;
    assign fall_o = ~sig_i & prev_reg;
endmodule : dsrp_edge

// [dsrp_conv.sv]
// Conversion sequencer paced by conversion clock falling edges
module dsrp_conv import dsrp_pkg::*; #(
    parameter int unsigned CONV_FALLS = CONV_FALLS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic start_i,
    input wire logic fall_i,
    output logic busy_o,
    output logic begin_o,
    output logic done_o
);
    dsrp_conv_t st_reg;
    logic [7:0] cnt_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= CV_IDLE;
            cnt_reg <= 8'h00;
            busy_o <= 1'b0;
            begin_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            begin_o <= 1'b0;
            done_o <= 1'b0;
            if (clr_i) begin
                st_reg <= CV_IDLE;
                cnt_reg <= 8'h00;
                busy_o <= 1'b0;
            end else begin
                unique case (st_reg)
                    CV_IDLE: if (start_i) begin
                        st_reg <= CV_WAIT;
                        cnt_reg <= 8'h00;
                        busy_o <= 1'b1;
                    end
                    CV_WAIT: if (fall_i) begin
                        if (cnt_reg == 8'(START_FALLS - 1)) begin
                            st_reg <= CV_RUN;
                            cnt_reg <= 8'h00;
                            begin_o <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg + 8'h01;
                        end
                    end
                    CV_RUN: if (fall_i) begin
                        if (cnt_reg == 8'(CONV_FALLS - 1)) begin
                            st_reg <= CV_IDLE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg + 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    property p_conv_begin;
        @(posedge clk_i) disable iff (!rst_n_i)
        begin_o |-> busy_o && $past(fall_i) && $past(st_reg) == CV_WAIT;
    endproperty
    a_conv_begin: assert property (p_conv_begin) else $error("conversion began off a clock fall");

    property p_busy_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (start_i && !clr_i && st_reg == CV_IDLE) |=> busy_o && !begin_o;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not raised on start");
endmodule : dsrp_conv

// [dsrp_top.sv]
// Serial command port and register bank of a data-acquisition converter
// Function
// - Instruction bit 7 picks convert or register; bits 6,5 read and wide; 4..0 address.
// - Convert instruction copies its low seven bits into gain/channel, then converts.
// - Address 0 gives low result nibble and overrange; address 1 the high byte.
// - Address 2 reads six amplifier limit flags; top two bits zero.
// - Address 3 holds read-back mode and clock divide; upper nibble zero.
// - Address 4 holds convert/busy, gain select and channel select.
// - Address 5 reads I/O pin levels and convert/busy; bits 6..4 zero.
// - Writing convert/busy as one starts a conversion; it reads one while busy.
// - Address 6 holds per-pin direction bits for the four I/O pins.
// - Address 7 holds oscillator and reference control bits.
// - Address 24 holds LSB-first, two-wire and legacy timing, mirrored in the byte.
// - Byte write of zero to address 0, or the reset pin, resets all.
// - Any reset clears every register, turning oscillator and reference off.
// - Eight zero bits then a one while awaiting instruction reset the device.
// - Chip select high resynchronises the port, registers untouched.
// - First active edge after select takes instruction bit one; edge pin picks polarity.
// - A started conversion begins on the second conversion clock fall.
// - Wide writes commit both bytes together; second address has bit 0 flipped.
// - Read data driven from the non-active edge after the instruction, changing there.
// - Two-wire return line released on non-active edge after last read bit.
// - Outputs high impedance while deselected; data out always driven while selected.
// - Each read byte is sampled at its first active edge; then await instruction.
// - Channel select drives the multiplexer; its bit 2 swaps differential polarity.
module dsrp_top import dsrp_pkg::*; #(
    parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
    parameter int unsigned CONV_FALLS = CONV_FALLS_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    input wire logic EDGE_RISE_I,
    input wire logic CONV_CLOCK_IN_I,
    input wire logic [3:0] IO_I,
    input wire logic [11:0] RESULT_I,
    input wire logic OVERRANGE_I,
    input wire logic [5:0] AMP_LIMIT_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    output logic SDI_O,
    output logic SDI_OE_O,
    output logic [3:0] IO_O,
    output logic [3:0] IO_OE_O,
    output logic [2:0] GAIN_SEL_O,
    output logic [3:0] CHANNEL_SEL_O,
    output logic [1:0] READBACK_MODE_O,
    output logic [1:0] CLK_DIVIDE_O,
    output logic OSC_SOURCE_SEL_O,
    output logic OSC_ON_O,
    output logic VREF_ON_O,
    output logic VREF_BUFFER_ON_O,
    output logic VREF_LEVEL_SEL_O,
    output logic VREF_LOW_SEL_O,
    output logic TWO_WIRE_O,
    output logic LEGACY_TIMING_O,
    output logic BUSY_O,
    output logic CONV_BEGIN_O
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic sclk_rise, sclk_fall, conv_clock_in_fall;
    logic act, nact;
    dsrp_state_t st_reg;
    logic [4:0] cnt_reg;
    logic [7:0] sh_reg, ins_reg, wb_reg, ob_reg, sh_next;
    logic [3:0] zrun_reg;
    logic [11:0] res_reg;
    logic ovr_reg;
    logic [5:0] amp_reg;
    logic [3:0] ctl_reg;
    logic [6:0] gm_reg;
    logic [3:0] io_out_reg;
    logic [3:0] oe_reg;
    logic [5:0] roc_reg;
    logic [2:0] spc_reg;
    logic busy, conv_done, conv_req;
    logic wide, zero_ctx, zero_hit, commit, dir_go, soft_clr, tx_bit;
    logic [4:0] len, addr_a, addr_b;
    logic [1:0] wr_v;
    logic [4:0] wr_a [2];
    logic [7:0] wr_d [2];

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [7:0] rd_byte(input logic [4:0] a);
        case (a)
            A_RES_LO: rd_byte = {res_reg[3:0], 3'h0, ovr_reg};
            A_RES_HI: rd_byte = res_reg[11:4];
            A_AMP: rd_byte = {2'h0, amp_reg};
            A_CONV_CTL: rd_byte = {4'h0, ctl_reg};
            A_GAIN_CH: rd_byte = {busy, gm_reg};
            A_IO_LVL: rd_byte = {busy, 3'h0, IO_I};
            A_IO_DIR: rd_byte = {4'h0, oe_reg};
            A_REF_OSC: rd_byte = {2'h0, roc_reg};
            A_SPC: rd_byte = {spc_reg[0], spc_reg[1], spc_reg[2], 2'h0, spc_reg[2], spc_reg[1], spc_reg[0]};
            A_ID: rd_byte = DEVICE_ID;
            default: rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    function automatic logic pick(input logic [7:0] b, input logic [2:0] k, input logic lsb);
        pick = lsb ? b[k] : b[3'h7 - k];
    endfunction : pick

    function automatic logic is_cnv(input logic [4:0] a, input logic [7:0] d);
        is_cnv = (a == A_GAIN_CH || a == A_IO_LVL) && d[CNV_BIT];
    endfunction : is_cnv

    // ----------------------------------------
    // Edge detection and sequencer
    // ----------------------------------------
    dsrp_edge u_sclk_edge (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .sig_i(SCLK_I),
        .rise_o(sclk_rise),
        .fall_o(sclk_fall)
    );

    dsrp_edge u_conv_clock_in_edge (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .sig_i(CONV_CLOCK_IN_I),
        .rise_o(),
        .fall_o(conv_clock_in_fall)
    );

    dsrp_conv #(
        .CONV_FALLS(CONV_FALLS)
    ) u_conv (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .clr_i(soft_clr),
        .start_i(conv_req),
        .fall_i(conv_clock_in_fall),
        .busy_o(busy),
        .begin_o(CONV_BEGIN_O),
        .done_o(conv_done)
    );

    // ----------------------------------------
    // Serial decode
    // ----------------------------------------
    assign act = ~CS_N_I & (EDGE_RISE_I ? sclk_rise : sclk_fall);
    assign nact = ~CS_N_I & (EDGE_RISE_I ? sclk_fall : sclk_rise);
    assign sh_next = spc_reg[SPC_LSB] ? {SDI_I, sh_reg[7:1]} : {sh_reg[6:0], SDI_I};
    assign wide = ins_reg[INS_WIDE];
    assign len = wide ? WORD_BITS : BYTE_BITS;
    assign addr_a = ins_reg[4:0];
    assign addr_b = {ins_reg[4:1], ~ins_reg[0]};
    assign zero_ctx = st_reg == ST_INSTR || (st_reg == ST_WDATA && ins_reg == RST_BYTE);
    assign zero_hit = act && SDI_I && zero_ctx && zrun_reg >= RESYNC_ZEROS;
    assign commit = act && st_reg == ST_WDATA && cnt_reg == len - 5'h01 && !zero_hit;
    assign dir_go = act && st_reg == ST_INSTR && cnt_reg == 5'h07 && sh_next[INS_DIRECT] && !zero_hit;
    assign wr_v = {commit & wide, commit};
    assign wr_a[0] = addr_a;
    assign wr_a[1] = addr_b;
    assign wr_d[0] = wide ? wb_reg : sh_next;
    assign wr_d[1] = sh_next;
    assign soft_clr = zero_hit || (commit && !wide && addr_a == A_RES_LO && sh_next == RST_BYTE);
    assign conv_req = dir_go || (wr_v[0] && is_cnv(wr_a[0], wr_d[0])) || (wr_v[1] && is_cnv(wr_a[1], wr_d[1]));
    assign tx_bit = (cnt_reg[2:0] == 3'h0) ? pick(rd_byte(cnt_reg[3] ? addr_b : addr_a), 3'h0, spc_reg[SPC_LSB])
                                           : pick(ob_reg, cnt_reg[2:0], spc_reg[SPC_LSB]);

    // ----------------------------------------
    // Serial state
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_reg <= ST_INSTR;
            cnt_reg <= 5'h00;
            ins_reg <= 8'h00;
        end else if (CS_N_I || soft_clr) begin
            st_reg <= ST_INSTR;
            cnt_reg <= 5'h00;
            ins_reg <= 8'h00;
        end else if (act) begin
            unique case (st_reg)
                ST_INSTR: if (cnt_reg == 5'h07) begin
                    cnt_reg <= 5'h00;
                    ins_reg <= sh_next;
                    if (!sh_next[INS_DIRECT]) begin
                        st_reg <= sh_next[INS_READ] ? ST_RDATA : ST_WDATA;
                    end
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
                ST_WDATA: if (cnt_reg == len - 5'h01) begin
                    st_reg <= ST_INSTR;
                    cnt_reg <= 5'h00;
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
                ST_RDATA: if (cnt_reg != len) begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
            endcase
        end else if (nact && st_reg == ST_RDATA && cnt_reg == len) begin
            st_reg <= ST_INSTR;
            cnt_reg <= 5'h00;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sh_reg <= 8'h00;
            wb_reg <= 8'h00;
        end else if (act) begin
            sh_reg <= sh_next;
            if (st_reg == ST_WDATA && cnt_reg == 5'h07) begin
                wb_reg <= sh_next;
            end
        end
    end

    // Zero run length while awaiting an instruction
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            zrun_reg <= 4'h0;
        end else if (CS_N_I || zero_hit) begin
            // Run survives a zero-write reset so a long zero string still ends in resync
            zrun_reg <= 4'h0;
        end else if (act) begin
            if (zero_ctx && !SDI_I) begin
                zrun_reg <= (zrun_reg < RESYNC_ZEROS) ? zrun_reg + 4'h1 : zrun_reg;
            end else begin
                zrun_reg <= 4'h0;
            end
        end
    end

    // ----------------------------------------
    // Read data out
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SDO_O <= 1'b0;
            SDO_OE_O <= 1'b0;
            SDI_O <= 1'b0;
            SDI_OE_O <= 1'b0;
            ob_reg <= 8'h00;
        end else begin
            SDO_OE_O <= ~CS_N_I;
            if (CS_N_I || soft_clr) begin
                SDO_O <= 1'b0;
                SDI_O <= 1'b0;
                SDI_OE_O <= 1'b0;
            end else if (st_reg == ST_RDATA) begin
                if (act && cnt_reg[2:0] == 3'h0 && cnt_reg != len) begin
                    ob_reg <= rd_byte(cnt_reg[3] ? addr_b : addr_a);
                end
                if (nact) begin
                    if (cnt_reg == len) begin
                        SDI_OE_O <= 1'b0;
                    end else begin
                        SDO_O <= tx_bit;
                        SDI_O <= tx_bit;
                        SDI_OE_O <= spc_reg[SPC_2W];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctl_reg <= 4'h0;
            gm_reg <= 7'h00;
            io_out_reg <= 4'h0;
            oe_reg <= 4'h0;
            roc_reg <= 6'h00;
            spc_reg <= 3'h0;
        end else if (soft_clr) begin
            ctl_reg <= 4'h0;
            gm_reg <= 7'h00;
            io_out_reg <= 4'h0;
            oe_reg <= 4'h0;
            roc_reg <= 6'h00;
            spc_reg <= 3'h0;
        end else begin
            if (dir_go) begin
                gm_reg <= sh_next[6:0];
            end
            for (int k = 0; k < 2; k++) begin
                if (wr_v[k]) begin
                    case (wr_a[k])
                        A_CONV_CTL: ctl_reg <= wr_d[k][3:0];
                        A_GAIN_CH: gm_reg <= wr_d[k][6:0];
                        A_IO_LVL: io_out_reg <= wr_d[k][3:0];
                        A_IO_DIR: oe_reg <= wr_d[k][3:0];
                        A_REF_OSC: roc_reg <= wr_d[k][5:0];
                        A_SPC: spc_reg <= {wr_d[k][5] | wr_d[k][2], wr_d[k][6] | wr_d[k][1],
                                           wr_d[k][7] | wr_d[k][0]};
                        default: ;
                    endcase
                end
            end
        end
    end

    // Conversion results
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            res_reg <= 12'h000;
            ovr_reg <= 1'b0;
            amp_reg <= 6'h00;
        end else if (soft_clr) begin
            res_reg <= 12'h000;
            ovr_reg <= 1'b0;
            amp_reg <= 6'h00;
        end else if (conv_done) begin
            res_reg <= RESULT_I;
            ovr_reg <= OVERRANGE_I;
            amp_reg <= AMP_LIMIT_I;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign IO_O = io_out_reg;
    assign IO_OE_O = oe_reg;
    assign GAIN_SEL_O = gm_reg[6:4];
    assign CHANNEL_SEL_O = gm_reg[3:0];
    assign READBACK_MODE_O = ctl_reg[3:2];
    assign CLK_DIVIDE_O = ctl_reg[1:0];
    assign OSC_SOURCE_SEL_O = roc_reg[5];
    assign OSC_ON_O = roc_reg[4];
    assign VREF_ON_O = roc_reg[3];
    assign VREF_BUFFER_ON_O = roc_reg[2];
    assign VREF_LEVEL_SEL_O = roc_reg[1];
    assign VREF_LOW_SEL_O = roc_reg[0];
    assign TWO_WIRE_O = spc_reg[SPC_2W];
    assign LEGACY_TIMING_O = spc_reg[SPC_LEG];
    assign BUSY_O = busy;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_instr_byte;
        act && st_reg == ST_INSTR && cnt_reg == 5'h07 && !zero_hit;
    endsequence
    sequence s_read_end;
        nact && st_reg == ST_RDATA && cnt_reg == len;
    endsequence

    property p_cs_hiz;
        CS_N_I |=> !SDO_OE_O && !SDI_OE_O;
    endproperty
    a_cs_hiz: assert property (p_cs_hiz) else $error("line driven while deselected");
    property p_cs_drive;
        !CS_N_I |=> SDO_OE_O;
    endproperty
    a_cs_drive: assert property (p_cs_drive) else $error("data out floats while selected");
    property p_resync;
        CS_N_I |=> st_reg == ST_INSTR && cnt_reg == 5'h00 && $stable(gm_reg) && $stable(oe_reg);
    endproperty
    a_resync: assert property (p_resync) else $error("deselect did not resync cleanly");
    property p_direct;
        s_instr_byte ##0 sh_next[INS_DIRECT] |=> gm_reg == 7'($past(sh_next)) ##1 st_reg == ST_INSTR;
    endproperty
    a_direct: assert property (p_direct) else $error("convert byte not copied");
    property p_soft;
        soft_clr |=> gm_reg == 7'h00 && roc_reg == 6'h00 && spc_reg == 3'h0 && res_reg == 12'h000;
    endproperty
    a_soft: assert property (p_soft) else $error("reset left a register set");
    property p_zero_seq;
        zero_hit |=> st_reg == ST_INSTR && cnt_reg == 5'h00 && zrun_reg == 4'h0 && !BUSY_O;
    endproperty
    a_zero_seq: assert property (p_zero_seq) else $error("zero run reset missed");
    property p_release;
        s_read_end |=> !SDI_OE_O && st_reg == ST_INSTR;
    endproperty
    a_release: assert property (p_release) else $error("return line not released");
    property p_unmapped;
        rd_byte(5'h08) == 8'h00 && rd_byte(5'h1e) == 8'h00 && rd_byte(A_AMP) < 8'h40;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address reads nonzero");
    property p_wide;
        act && st_reg == ST_WDATA && wide && cnt_reg == 5'h0f && !zero_hit && addr_a == A_REF_OSC
            |=> roc_reg == 6'($past(wb_reg)) && oe_reg == 4'($past(sh_next));
    endproperty
    a_wide: assert property (p_wide) else $error("paired write not committed together");
endmodule : dsrp_top

// [dsrp_host.sv]
// Host-side serial master model for the register port
module dsrp_host (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Bits MSB first: fall, settle, sample, rise
    task automatic shift(input int n, input logic [15:0] d, output logic [15:0] q);
        q = 16'h0000;
        cs_n_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            sdi_o <= d[i];
            repeat (4) @(posedge clk_i);
            q[i] = sdo_i;
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask : shift
    // Frame end: trailing non-active edge, then deselect; released data line shows no stale level
    task automatic idle();
        @(posedge clk_i);
        sclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        sdi_o <= ~sdi_o;
        repeat (4) @(posedge clk_i);
    endtask : idle
endmodule : dsrp_host

// [tb.sv]
// Testbench: register port exercised through the host model
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] cc = 6'h00;
    logic cs_n, sclk, sdi_h, sdo, sdo_oe, sdi_d, sdi_oe, busy, vref, osc, two_w, conv_go;
    logic [3:0] io_lvl = 4'ha;
    logic [3:0] io_out, ioe, chan;
    int n_begin = 0;
    logic [2:0] gain;
    logic [1:0] cdiv;
    logic [15:0] q;
    int n_fail = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    always_ff @(posedge clk) cc <= cc + 6'h01;
    always_ff @(posedge clk) begin
        if (conv_go) begin
            n_begin <= n_begin + 1;
        end
    end
    dsrp_top #(.DEVICE_ID(DEV_ID), .CONV_FALLS(4)) dut (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CS_N_I(cs_n), .SCLK_I(sclk),
        .SDI_I(sdi_oe ? sdi_d : sdi_h), .EDGE_RISE_I(1'b1), .CONV_CLOCK_IN_I(cc[5]), .IO_I(io_lvl),
        .RESULT_I(12'h9c3), .OVERRANGE_I(1'b1), .AMP_LIMIT_I(6'h2d), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
        .SDI_O(sdi_d), .SDI_OE_O(sdi_oe), .IO_O(io_out), .IO_OE_O(ioe), .GAIN_SEL_O(gain), .CHANNEL_SEL_O(chan),
        .READBACK_MODE_O(), .CLK_DIVIDE_O(cdiv), .OSC_SOURCE_SEL_O(), .OSC_ON_O(osc), .VREF_ON_O(vref),
        .VREF_BUFFER_ON_O(), .VREF_LEVEL_SEL_O(), .VREF_LOW_SEL_O(), .TWO_WIRE_O(two_w), .LEGACY_TIMING_O(),
        .BUSY_O(busy), .CONV_BEGIN_O(conv_go));
    dsrp_host h (.clk_i(clk), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi_h));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] ins, input int n, input logic [15:0] d);
        h.shift(8, {8'h00, ins}, q);
        h.shift(n, d, q);
        h.idle();
    endtask : wr
    task automatic rchk(input logic [7:0] ins, input int n, input logic [15:0] e);
        h.shift(8, {8'h00, ins}, q);
        h.shift(n, 16'h0000, q);
        `CHK(sdo_oe, 1'b1)
        h.idle();
        `CHK(sdo_oe, 1'b0)
        `CHK(q, e)
    endtask : rchk
    // Bounded wait for the converter to go idle
    task automatic wait_idle();
        int k;
        for (k = 0; k < 2000 && busy !== 1'b0; k++) begin
            @(posedge clk);
        end
        if (k == 2000) begin
            n_fail++;
        end
    endtask : wait_idle
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h5f, 8, {8'h00, DEV_ID});
        rchk(8'h58, 8, 16'h0000);
        wr(8'h03, 8, 16'h00ff);
        rchk(8'h43, 8, 16'h000f);
        `CHK(cdiv, 2'h3)
        wr(8'h27, 16, 16'hff2c);
        rchk(8'h66, 16, 16'h0c3f);
        `CHK({osc, vref}, 2'h3)
        `CHK(ioe, 4'hc)
        wr(8'h08, 8, 16'h005a);
        rchk(8'h48, 8, 16'h0000);
        rchk(8'h45, 8, 16'h000a);
        io_lvl <= 4'h5;
        rchk(8'h45, 8, 16'h0005);
        wr(8'hb5, 0, 16'h0000);
        `CHK(gain, 3'h3)
        `CHK(chan, 4'h5)
        rchk(8'h44, 8, 16'h00b5);
        wait_idle();
        rchk(8'h60, 16, 16'h319c);
        rchk(8'h42, 8, 16'h002d);
        wr(8'h05, 8, 16'h0083);
        `CHK(busy, 1'b1)
        `CHK(io_out, 4'h3)
        wait_idle();
        wr(8'h18, 8, 16'h0042);
        `CHK(two_w, 1'b1)
        rchk(8'h58, 8, 16'h0042);
        wr(8'h00, 8, 16'h0000);
        `CHK({osc, vref, two_w}, 3'h0)
        rchk(8'h67, 16, 16'h0000);
        wr(8'h07, 8, 16'h0015);
        h.shift(9, 16'h0001, q);
        rchk(8'h47, 8, 16'h0000);
        h.shift(4, 16'h000f, q);
        h.idle();
        wr(8'h07, 8, 16'h0015);
        rchk(8'h47, 8, 16'h0015);
        h.shift(3, 16'h0003, q);
        h.shift(16, 16'h0000, q);
        h.shift(16, 16'h0000, q);
        h.shift(8, 16'h0001, q);
        rchk(8'h47, 8, 16'h0000);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h47, 8, 16'h0000);
        `CHK(n_begin, 2)
        stop_test();
    end
endmodule : tb
